/* common/sbm_pkg.sv */
`default_nettype none
package sbm_pkg;
	// Bus sequencing states, one per system bus clock
	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_REQ  = 4'h1,
		ST_RQ1  = 4'h2,
		ST_RQ2  = 4'h3,
		ST_ARB  = 4'h4,
		ST_OWN  = 4'h5,
		ST_TX   = 4'h6,
		ST_T1   = 4'h7,
		ST_T2   = 4'h8,
		ST_T3   = 4'h9,
		ST_T4   = 4'ha,
		ST_HALT = 4'hb,
		ST_I1   = 4'hc,
		ST_I2   = 4'hd
	} bus_state_t;

	// Cycle termination kinds
	typedef enum logic [1:0] {
		TERM_NORMAL = 2'h0,
		TERM_ERROR  = 2'h1,
		TERM_RERUN  = 2'h2
	} term_t;

	localparam int ADDR_W  = 32;
	localparam int DATA_W  = 16;
	localparam int RETRY_W = 8;

	// Synchronised input vector layout
	localparam int SYNC_W      = 7;
	localparam int SY_HOLD_ACK = 0;
	localparam int SY_BUSY     = 1;
	localparam int SY_GRANT_N  = 2;
	localparam int SY_ERR_N    = 3;
	localparam int SY_ACK_N    = 4;
	localparam int SY_HALT_N   = 5;
	localparam int SY_WAIT     = 6;
	localparam logic [SYNC_W-1:0] SYNC_RST = 7'h3e;

	localparam logic [DATA_W-1:0] AD_RST = 16'h0000;
endpackage : sbm_pkg
`default_nettype wire

/* common/sync_if.sv */
`default_nettype none
interface sync_if;
	logic [sbm_pkg::SYNC_W-1:0] raw;
	logic [sbm_pkg::SYNC_W-1:0] synced;
	modport syncer (input raw, output synced);
	modport user (output raw, input synced);
endinterface : sync_if
`default_nettype wire

/* src/arb_sync.sv */
`default_nettype none
module arb_sync
	import sbm_pkg::*;
(
	input  wire logic i_sys_clk,
	input  wire logic i_arst_n,
	sync_if.syncer    s
);
	logic [SYNC_W-1:0] meta_reg;
	logic [SYNC_W-1:0] stable_reg;

	always_ff @(negedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			meta_reg   <= SYNC_RST;
			stable_reg <= SYNC_RST;
		end else begin
			meta_reg   <= s.raw;
			stable_reg <= meta_reg;
		end
	end

	assign s.synced = stable_reg;
endmodule : arb_sync
`default_nettype wire

/* src/sys_bus_master.sv */
// Summary of operation
// - Hold mode: raise hold request on a rising clock edge.
// - Request, acknowledge and busy all high at falling edge: assert ownership next rise.
// - Data direction set for the transfer together with ownership.
// - Extended phase puts address bits 31..16 on the bus halves.
// - Read and write strobes driven inactive high mid extended phase.
// - End of extended phase: address 15..0 out, upper byte enable set.
// - Falling edge ending T1 drops write or read strobe.
// - At least two idle clocks in every bus handoff.
// - Final T4: float strobes and bus, drive byte enable high then float.
// - Release: hold request low at I1, ownership and direction high at I2.
// - Grant mode read: data strobes follow address strobe, read line high.
// - Grant mode read: direction low, transceiver enabled mid cycle.
// - Grant mode write: read line low, data strobes one clock late.
// - Grant mode single byte: unused bus half floats.
// - Grant high at falling edge: bus request low on second rising edge.
// - Take bus when request, grant low and busy, error, acknowledge, address and data strobes idle high.
// - After ownership, glue holds acknowledge; bus request may drop.
// - Grant and busy pass two synchroniser stages.
// - Arbitration inputs sampled on falling edges, outputs change on rising.
// - Grant mode recognises bus error, rerun and halt each cycle.
// - Bus error retries while count nonzero, else aborts.
// - Rerun repeats without count change; halt idles after the cycle.
`default_nettype none
module sys_bus_master
	import sbm_pkg::*;
(
	input  wire logic                i_sys_clk,
	input  wire logic                i_arst_n,
	input  wire logic                i_req_grant_mode,
	input  wire logic                i_dma_req,
	input  wire logic                i_dma_write,
	input  wire logic                i_dma_last,
	input  wire logic                i_dma_byte,
	input  wire logic [ADDR_W-1:0]   i_dma_addr,
	input  wire logic [DATA_W-1:0]   i_dma_wdata,
	input  wire logic [RETRY_W-1:0]  i_error_retry_count,
	output logic                     o_dma_ack,
	output logic                     o_dma_abort,
	output logic [DATA_W-1:0]        o_dma_rdata,
	input  wire logic                i_hold_ack_in,
	input  wire logic                i_bus_busy_in,
	input  wire logic                i_bus_grant_in_n,
	input  wire logic                i_bus_error_in_n,
	input  wire logic                i_transfer_ack_in_n,
	input  wire logic                i_halt_in_n,
	input  wire logic                i_slave_wait_request,
	output logic                     o_hold_request_out,
	output logic                     o_bus_request_out_n,
	output logic                     o_bus_owned_out_n,
	output logic                     o_data_direction_out,
	output logic                     o_read_strobe_n,
	output logic                     o_write_strobe_n,
	output logic                     o_strobe_oe,
	input  wire logic [DATA_W-1:0]   i_muxed_addr_data_bus,
	output logic [DATA_W-1:0]        o_muxed_addr_data_bus,
	output logic                     o_addr_data_high_half_oe,
	output logic                     o_addr_data_low_half_oe,
	output logic                     o_upper_byte_or_read_not_write,
	output logic                     o_upper_byte_or_read_not_write_oe,
	output logic                     o_address_latch_strobe,
	output logic                     o_address_strobe_out_n,
	output logic                     o_upper_data_strobe_n,
	output logic                     o_lower_data_strobe_n,
	output logic                     o_transceiver_enable_n
);
	default disable iff (!i_arst_n);

	function automatic logic [1:0] half_sel(input logic byte_x, input logic a0);
		half_sel = byte_x ? {a0, !a0} : 2'h3;
	endfunction : half_sel

	sync_if sy ();
	arb_sync u_sync (
		.i_sys_clk (i_sys_clk),
		.i_arst_n  (i_arst_n),
		.s         (sy.syncer)
	);
	assign sy.raw = {i_slave_wait_request, i_halt_in_n, i_transfer_ack_in_n,
		i_bus_error_in_n, i_bus_grant_in_n, i_bus_busy_in, i_hold_ack_in};

	logic hold_ack_s, busy_s, grant_n_s, err_n_s, ack_n_s, halt_n_s, wait_s;
	assign hold_ack_s = sy.synced[SY_HOLD_ACK];
	assign busy_s     = sy.synced[SY_BUSY];
	assign grant_n_s  = sy.synced[SY_GRANT_N];
	assign err_n_s    = sy.synced[SY_ERR_N];
	assign ack_n_s    = sy.synced[SY_ACK_N];
	assign halt_n_s   = sy.synced[SY_HALT_N];
	assign wait_s     = sy.synced[SY_WAIT];

	bus_state_t          state_reg, state_next;
	term_t               term_reg;
	logic                take, cont, halt_ok, t3_done, mode_reg;
	logic                halt_pend_reg, again_reg, t3_dwell_reg;
	logic                write_reg, byte_reg, last_reg;
	logic [ADDR_W-1:0]   addr_reg;
	logic [DATA_W-1:0]   wdata_reg, ad_reg, rdata_reg;
	logic [RETRY_W-1:0]  retry_reg;
	logic [1:0]          halves, ad_oe_reg;
	logic                hold_req_reg, bus_req_n_reg, owned_n_reg, dir_reg, rw_oe_reg;
	logic                rd_n_reg, wr_n_reg, as_n_reg, uds_n_reg, lds_n_reg;
	logic                bhe_reg, bhe_oe_reg, ale_reg, xcvr_n_reg, ack_reg, abort_reg;

	assign halves  = half_sel(byte_reg, addr_reg[0]);
	assign cont    = !last_reg && i_dma_req;
	assign halt_ok = !mode_reg || halt_n_s;
	assign t3_done = mode_reg ? (!ack_n_s || !err_n_s) : (!wait_s && t3_dwell_reg);

	always_comb begin
		state_next = state_reg;
		take       = 1'b0;
		case (state_reg)
			ST_IDLE: if (i_dma_req) begin
				state_next = ST_REQ;
				take       = 1'b1;
			end
			ST_REQ: if (mode_reg) begin
				if (grant_n_s) state_next = ST_RQ1;
			end else if (!hold_ack_s) begin
				state_next = ST_ARB;
			end
			ST_RQ1: state_next = ST_RQ2;
			ST_RQ2: state_next = ST_ARB;
			ST_ARB: if (mode_reg) begin
				if (!bus_req_n_reg && !grant_n_s && busy_s && err_n_s && ack_n_s &&
					as_n_reg && uds_n_reg && lds_n_reg) state_next = ST_OWN;
			end else if (hold_req_reg && hold_ack_s && busy_s) begin
				state_next = ST_OWN;
			end
			ST_OWN: state_next = halt_ok ? ST_TX : ST_HALT;
			ST_TX:  state_next = ST_T1;
			ST_T1:  state_next = ST_T2;
			ST_T2:  state_next = ST_T3;
			ST_T3:  if (t3_done) state_next = ST_T4;
			ST_T4: begin
				if (term_reg == TERM_ERROR && retry_reg != '0) begin
					state_next = halt_ok ? ST_TX : ST_HALT;
				end else if (term_reg == TERM_ERROR) begin
					state_next = ST_I1;
				end else if (term_reg == TERM_RERUN || halt_pend_reg) begin
					state_next = ST_HALT;
				end else if (cont) begin
					state_next = ST_TX;
					take       = 1'b1;
				end else begin
					state_next = ST_I1;
				end
			end
			ST_HALT: if (halt_ok) begin
				if (again_reg) begin
					state_next = ST_TX;
				end else if (cont) begin
					state_next = ST_TX;
					take       = 1'b1;
				end else begin
					state_next = ST_I1;
				end
			end
			ST_I1: state_next = ST_I2;
			ST_I2: state_next = ST_IDLE;
			default: state_next = ST_IDLE;
		endcase
	end

	always_ff @(negedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) state_reg <= ST_IDLE;
		else state_reg <= state_next;
	end

	// wait sampled at T2 end reaches logic
	always_ff @(negedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) t3_dwell_reg <= 1'b0;
		else t3_dwell_reg <= state_reg == ST_T3;
	end

	// Transfer parameters
	always_ff @(negedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			addr_reg  <= '0;
			wdata_reg <= AD_RST;
			write_reg <= 1'b0;
			byte_reg  <= 1'b0;
			last_reg  <= 1'b1;
		end else if (take) begin
			addr_reg  <= i_dma_addr;
			wdata_reg <= i_dma_wdata;
			write_reg <= i_dma_write;
			byte_reg  <= i_dma_byte;
			last_reg  <= i_dma_last;
		end
	end

	always_ff @(negedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) mode_reg <= 1'b0;
		else if (take && state_reg == ST_IDLE) mode_reg <= i_req_grant_mode;
	end

	always_ff @(negedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			retry_reg <= '0;
		end else if (take && state_reg == ST_IDLE) begin
			retry_reg <= i_error_retry_count;
		end else if (state_reg == ST_T4 && term_reg == TERM_ERROR && retry_reg != '0) begin
			retry_reg <= retry_reg - 1'b1;
		end
	end

	always_ff @(negedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			term_reg      <= TERM_NORMAL;
			halt_pend_reg <= 1'b0;
		end else if (state_reg == ST_T3 && t3_done) begin
			if (mode_reg && !err_n_s && !halt_n_s) term_reg <= TERM_RERUN;
			else if (mode_reg && !err_n_s) term_reg <= TERM_ERROR;
			else term_reg <= TERM_NORMAL;
			halt_pend_reg <= mode_reg && !halt_n_s;
		end
	end

	always_ff @(negedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) again_reg <= 1'b0;
		else if (state_reg == ST_TX) again_reg <= 1'b0;
		else if (state_reg == ST_OWN && !halt_ok) again_reg <= 1'b1;
		else if (state_reg == ST_T4 && (term_reg == TERM_RERUN ||
			(term_reg == TERM_ERROR && retry_reg != '0))) again_reg <= 1'b1;
	end

	// User completion pulses and read data
	always_ff @(negedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ack_reg   <= 1'b0;
			abort_reg <= 1'b0;
			rdata_reg <= AD_RST;
		end else begin
			ack_reg   <= state_reg == ST_T4 && term_reg == TERM_NORMAL;
			abort_reg <= state_reg == ST_T4 && term_reg == TERM_ERROR && retry_reg == '0;
			if (state_reg == ST_T3 && t3_done && !write_reg) rdata_reg <= i_muxed_addr_data_bus;
		end
	end

	// Address and data path
	always_ff @(negedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ad_reg    <= AD_RST;
			ad_oe_reg <= 2'h0;
		end else if (state_next == ST_TX) begin
			ad_reg    <= addr_reg[31:16];
			ad_oe_reg <= 2'h3;
		end else if (state_reg == ST_TX) begin
			ad_reg    <= addr_reg[15:0];
			ad_oe_reg <= 2'h3;
		end else if (state_reg == ST_T1) begin
			ad_reg    <= wdata_reg;
			ad_oe_reg <= write_reg ? halves : 2'h0;
		end else if (state_next == ST_T4) begin
			ad_oe_reg <= 2'h0;
		end
	end

	// Byte enable or read line
	always_ff @(negedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			bhe_reg    <= 1'b1;
			bhe_oe_reg <= 1'b0;
		end else if (state_next == ST_TX) begin
			bhe_oe_reg <= 1'b1;
		end else if (state_reg == ST_TX) begin
			bhe_reg <= mode_reg ? !write_reg : !halves[1];
		end else if (state_next == ST_T4) begin
			bhe_reg <= 1'b1;
		end else if (state_reg == ST_T4) begin
			bhe_oe_reg <= 1'b0;
		end
	end

	always_ff @(negedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rd_n_reg <= 1'b1;
			wr_n_reg <= 1'b1;
		end else if (state_reg == ST_T1 && !mode_reg) begin
			rd_n_reg <= write_reg;
			wr_n_reg <= !write_reg;
		end else if (state_reg == ST_T3 && t3_done) begin
			rd_n_reg <= 1'b1;
			wr_n_reg <= 1'b1;
		end
	end

	always_ff @(negedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			as_n_reg  <= 1'b1;
			uds_n_reg <= 1'b1;
			lds_n_reg <= 1'b1;
		end else if (state_reg == ST_T1 && mode_reg) begin
			as_n_reg  <= 1'b0;
			uds_n_reg <= write_reg | !halves[1];
			lds_n_reg <= write_reg | !halves[0];
		end else if (state_reg == ST_T2 && mode_reg && write_reg) begin
			uds_n_reg <= !halves[1];
			lds_n_reg <= !halves[0];
		end else if (state_reg == ST_T3 && t3_done) begin
			as_n_reg  <= 1'b1;
			uds_n_reg <= 1'b1;
			lds_n_reg <= 1'b1;
		end
	end

	always_ff @(negedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) xcvr_n_reg <= 1'b1;
		else if (state_reg == ST_T1) xcvr_n_reg <= 1'b0;
		else if (state_reg == ST_T3 && t3_done) xcvr_n_reg <= 1'b1;
	end

	always_ff @(negedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) ale_reg <= 1'b0;
		else ale_reg <= state_next == ST_TX || (state_reg == ST_TX);
	end

	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			hold_req_reg <= 1'b0;
		end else if (state_reg == ST_REQ && !mode_reg) begin
			hold_req_reg <= 1'b1;
		end else if (state_reg == ST_I1) begin
			hold_req_reg <= 1'b0;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			bus_req_n_reg <= 1'b1;
		end else if (state_reg == ST_RQ2) begin
			bus_req_n_reg <= 1'b0;
		end else if (state_reg == ST_TX) begin
			bus_req_n_reg <= 1'b1;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			owned_n_reg <= 1'b1;
			dir_reg     <= 1'b1;
		end else if (state_reg == ST_OWN) begin
			owned_n_reg <= 1'b0;
			dir_reg     <= write_reg;
		end else if (state_reg == ST_I2) begin
			owned_n_reg <= 1'b1;
			dir_reg     <= 1'b1;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) rw_oe_reg <= 1'b0;
		else if (state_reg == ST_TX && !mode_reg) rw_oe_reg <= 1'b1;
		else if (state_reg == ST_T4 || state_reg == ST_HALT) rw_oe_reg <= 1'b0;
	end

	assign o_dma_ack                         = ack_reg;
	assign o_dma_abort                       = abort_reg;
	assign o_dma_rdata                       = rdata_reg;
	assign o_hold_request_out                = hold_req_reg;
	assign o_bus_request_out_n               = bus_req_n_reg;
	assign o_bus_owned_out_n                 = owned_n_reg;
	assign o_data_direction_out              = dir_reg;
	assign o_read_strobe_n                   = rd_n_reg;
	assign o_write_strobe_n                  = wr_n_reg;
	assign o_strobe_oe                       = rw_oe_reg;
	assign o_muxed_addr_data_bus             = ad_reg;
	assign o_addr_data_high_half_oe          = ad_oe_reg[1];
	assign o_addr_data_low_half_oe           = ad_oe_reg[0];
	assign o_upper_byte_or_read_not_write    = bhe_reg;
	assign o_upper_byte_or_read_not_write_oe = bhe_oe_reg;
	assign o_address_latch_strobe            = ale_reg;
	assign o_address_strobe_out_n            = as_n_reg;
	assign o_upper_data_strobe_n             = uds_n_reg;
	assign o_lower_data_strobe_n             = lds_n_reg;
	assign o_transceiver_enable_n            = xcvr_n_reg;

	sequence release_seq;
		state_reg == ST_I1 ##1 state_reg == ST_I2 ##1 state_reg == ST_IDLE;
	endsequence
	sequence grant_seq;
		state_reg == ST_RQ1 ##1 state_reg == ST_RQ2;
	endsequence

	hold_req_rise_a: assert property (@(posedge i_sys_clk)
		(state_reg == ST_REQ && !mode_reg) |=> hold_req_reg)
		else $error("hold request not raised");
	own_assert_a: assert property (@(negedge i_sys_clk)
		(state_reg == ST_ARB && !mode_reg && hold_req_reg && hold_ack_s && busy_s)
		|=> state_reg == ST_OWN ##1 !owned_n_reg)
		else $error("ownership not taken");
	dir_with_own_a: assert property (@(posedge i_sys_clk)
		$fell(owned_n_reg) |-> dir_reg == write_reg)
		else $error("direction wrong at ownership");
	ext_addr_a: assert property (@(negedge i_sys_clk)
		state_reg == ST_TX |-> ad_reg == addr_reg[31:16] && ad_oe_reg == 2'h3)
		else $error("extended address wrong");
	strobe_high_a: assert property (@(posedge i_sys_clk)
		(state_reg == ST_TX && !mode_reg) |=> rw_oe_reg && rd_n_reg && wr_n_reg)
		else $error("strobes not high in extended phase");
	low_addr_a: assert property (@(negedge i_sys_clk)
		state_reg == ST_T1 |-> ad_reg == addr_reg[15:0])
		else $error("low address wrong");
	strobe_low_a: assert property (@(negedge i_sys_clk)
		(state_reg == ST_T2 && !mode_reg) |-> rd_n_reg == write_reg && wr_n_reg == !write_reg)
		else $error("strobe not asserted after T1");
	idle_gap_a: assert property (@(negedge i_sys_clk)
		(state_reg == ST_T4 && state_next == ST_I1) |=> release_seq)
		else $error("handoff idle clocks missing");
	bus_float_a: assert property (@(negedge i_sys_clk)
		state_reg == ST_T4 |-> ad_oe_reg == 2'h0 && bhe_reg)
		else $error("bus not floated in T4");
	release_own_a: assert property (@(posedge i_sys_clk)
		state_reg == ST_I2 |=> owned_n_reg && dir_reg && !hold_req_reg)
		else $error("release incomplete");
	grant_req_a: assert property (@(negedge i_sys_clk)
		(state_reg == ST_REQ && mode_reg && grant_n_s) |=> bus_req_n_reg ##0 grant_seq ##0
		!bus_req_n_reg)
		else $error("bus request timing wrong");
	byte_float_a: assert property (@(negedge i_sys_clk)
		(state_reg == ST_T3 && mode_reg && write_reg && byte_reg) |-> ad_oe_reg != 2'h3)
		else $error("unused half driven");
	retry_dec_a: assert property (@(negedge i_sys_clk)
		(state_reg == ST_T4 && term_reg == TERM_ERROR && retry_reg != '0)
		|=> retry_reg == $past(retry_reg) - 1'b1)
		else $error("retry count not decremented");
endmodule : sys_bus_master
`default_nettype wire

/* test/host_model.sv */
`default_nettype none
module host_model
	import sbm_pkg::*;
#(
	parameter logic [DATA_W-1:0] RDATA = 16'ha55a
)
(
	input  wire logic              i_sys_clk,
	input  wire logic              i_arst_n,
	input  wire logic              i_mode,
	input  wire logic [1:0]        i_err_mode,
	input  wire logic [3:0]        i_waits,
	input  wire logic              i_hold_req,
	input  wire logic              i_breq_n,
	input  wire logic              i_own_n,
	input  wire logic              i_rd_n,
	input  wire logic              i_wr_n,
	input  wire logic              i_as_n,
	output logic                   o_hold_ack,
	output logic                   o_busy,
	output logic                   o_grant_n,
	output logic                   o_err_n,
	output logic                   o_ack_n,
	output logic                   o_halt_n,
	output logic                   o_wait,
	output logic [DATA_W-1:0]      o_bus
);
	timeunit 1ns;
	timeprecision 1ns;
	logic       active;
	logic       err_on;
	logic [3:0] cnt_reg;
	logic       err_done_reg;
	assign active = i_mode ? !i_as_n : (!i_rd_n || !i_wr_n);
	assign err_on = (i_err_mode == 2'h2) || (i_err_mode[0] && !err_done_reg);
	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_hold_ack <= 1'b0;
			o_busy <= 1'b1;
			o_grant_n <= 1'b1;
			o_err_n <= 1'b1;
			o_halt_n <= 1'b1;
			o_ack_n <= 1'b1;
			o_wait <= 1'b0;
			o_bus <= 16'h0000;
			cnt_reg <= 4'h0;
			err_done_reg <= 1'b0;
		end else begin
			o_hold_ack <= i_hold_req;
			o_busy <= i_own_n;
			o_grant_n <= !(!i_breq_n && i_own_n);
			cnt_reg <= active ? cnt_reg + 4'h1 : 4'h0;
			o_wait <= active && (cnt_reg < i_waits);
			o_ack_n <= !(active && !err_on && (cnt_reg >= i_waits));
			o_err_n <= !(active && err_on);
			// Mode 3: error with halt asks for a rerun
			o_halt_n <= !(active && err_on && i_err_mode == 2'h3);
			err_done_reg <= (i_err_mode != 2'h0) && (err_done_reg || !o_err_n);
			o_bus <= active ? RDATA : ~o_bus;
		end
	end
endmodule : host_model
`default_nettype wire

/* test/sys_bus_master_tb.sv */
`default_nettype none
module sys_bus_master_tb
	import sbm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_sys_clk, i_arst_n, i_req_grant_mode, i_dma_req, i_dma_write, i_dma_last, i_dma_byte;
	logic [ADDR_W-1:0]  i_dma_addr;
	logic [DATA_W-1:0]  i_dma_wdata, o_dma_rdata, i_muxed_addr_data_bus, o_muxed_addr_data_bus;
	logic [DATA_W-1:0]  m_bus, cap0, cap1, wr_val, stb_len;
	logic [RETRY_W-1:0] i_error_retry_count;
	logic i_hold_ack_in, i_bus_busy_in, i_bus_grant_in_n, i_bus_error_in_n;
	logic i_transfer_ack_in_n, i_halt_in_n, i_slave_wait_request;
	logic o_dma_ack, o_dma_abort, o_hold_request_out, o_bus_request_out_n, o_bus_owned_out_n;
	logic o_data_direction_out, o_read_strobe_n, o_write_strobe_n, o_strobe_oe;
	logic o_addr_data_high_half_oe, o_addr_data_low_half_oe, o_upper_byte_or_read_not_write;
	logic o_upper_byte_or_read_not_write_oe, o_address_latch_strobe, o_address_strobe_out_n;
	logic o_upper_data_strobe_n, o_lower_data_strobe_n, o_transceiver_enable_n;
	logic [1:0] err_mode, ale_c;
	logic [3:0] waits;
	logic rd_lo, wr_lo, ten_lo, dir_own, own_seen, rnw_lo, hi_oe, ds_diff, breq_lo, ack_s, abt_s;
	int n_fail, n_checks;

	sys_bus_master u_dut (
		.i_sys_clk, .i_arst_n, .i_req_grant_mode, .i_dma_req, .i_dma_write, .i_dma_last,
		.i_dma_byte, .i_dma_addr, .i_dma_wdata, .i_error_retry_count, .o_dma_ack, .o_dma_abort,
		.o_dma_rdata, .i_hold_ack_in, .i_bus_busy_in, .i_bus_grant_in_n, .i_bus_error_in_n,
		.i_transfer_ack_in_n, .i_halt_in_n, .i_slave_wait_request, .o_hold_request_out,
		.o_bus_request_out_n, .o_bus_owned_out_n, .o_data_direction_out, .o_read_strobe_n,
		.o_write_strobe_n, .o_strobe_oe, .i_muxed_addr_data_bus, .o_muxed_addr_data_bus,
		.o_addr_data_high_half_oe, .o_addr_data_low_half_oe, .o_upper_byte_or_read_not_write,
		.o_upper_byte_or_read_not_write_oe, .o_address_latch_strobe, .o_address_strobe_out_n,
		.o_upper_data_strobe_n, .o_lower_data_strobe_n, .o_transceiver_enable_n
	);
	host_model u_host (
		.i_sys_clk, .i_arst_n, .i_mode(i_req_grant_mode), .i_err_mode(err_mode), .i_waits(waits),
		.i_hold_req(o_hold_request_out), .i_breq_n(o_bus_request_out_n),
		.i_own_n(o_bus_owned_out_n), .i_rd_n(o_read_strobe_n), .i_wr_n(o_write_strobe_n),
		.i_as_n(o_address_strobe_out_n), .o_hold_ack(i_hold_ack_in), .o_busy(i_bus_busy_in),
		.o_grant_n(i_bus_grant_in_n), .o_err_n(i_bus_error_in_n), .o_ack_n(i_transfer_ack_in_n),
		.o_halt_n(i_halt_in_n), .o_wait(i_slave_wait_request), .o_bus(m_bus)
	);
	assign i_muxed_addr_data_bus = {o_addr_data_high_half_oe ? o_muxed_addr_data_bus[15:8] :
		m_bus[15:8], o_addr_data_low_half_oe ? o_muxed_addr_data_bus[7:0] : m_bus[7:0]};

	initial begin
		i_sys_clk = 1'b0;
		forever #10 i_sys_clk = ~i_sys_clk;
	end

	always @(posedge i_sys_clk) begin
		#5;
		if (o_address_latch_strobe === 1'b1) begin
			if (ale_c == 2'h0) cap0 = o_muxed_addr_data_bus;
			if (ale_c == 2'h1) cap1 = o_muxed_addr_data_bus;
			ale_c = ale_c + 2'h1;
		end
		if (o_strobe_oe === 1'b1 && o_read_strobe_n === 1'b0) rd_lo = 1'b1;
		if (o_strobe_oe === 1'b1 && o_write_strobe_n === 1'b0) begin
			wr_lo = 1'b1;
			stb_len = stb_len + 16'h0001;
		end
		if ((o_strobe_oe === 1'b1 && o_write_strobe_n === 1'b0) || o_lower_data_strobe_n === 1'b0)
			wr_val = o_muxed_addr_data_bus;
		if (o_transceiver_enable_n === 1'b0) ten_lo = 1'b1;
		if (o_bus_owned_out_n === 1'b0 && !own_seen) begin
			own_seen = 1'b1;
			dir_own = o_data_direction_out;
		end
		if (o_address_strobe_out_n === 1'b0 && o_upper_byte_or_read_not_write === 1'b0) rnw_lo = 1'b1;
		if (o_lower_data_strobe_n === 1'b0 && o_addr_data_high_half_oe !== 1'b0) hi_oe = 1'b1;
		if (o_address_strobe_out_n !== o_upper_data_strobe_n) ds_diff = 1'b1;
		if (o_bus_request_out_n === 1'b0) breq_lo = 1'b1;
	end

	task automatic results;
		if (n_fail == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : results

	task automatic chk1(input string nm, input logic exp, input logic got);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %b seen %b", nm, exp, got);
		end
	endtask : chk1

	task automatic chk16(input string nm, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk16

	task automatic xfer(input logic m, w, b, input logic [31:0] a, input logic [15:0] d,
		input logic [7:0] r, input logic [1:0] e, input logic [3:0] ws);
		int k;
		{rd_lo, wr_lo, ten_lo, own_seen, rnw_lo, hi_oe, ds_diff, breq_lo} = 8'h00;
		ale_c = 2'h0;
		stb_len = 16'h0000;
		err_mode = e;
		waits = ws;
		i_req_grant_mode = m;
		i_dma_write = w;
		i_dma_byte = b;
		i_dma_addr = a;
		i_dma_wdata = d;
		i_error_retry_count = r;
		i_dma_req = 1'b1;
		k = 0;
		while (o_dma_ack !== 1'b1 && o_dma_abort !== 1'b1 && k < 300) begin
			@(posedge i_sys_clk);
			#1;
			k++;
		end
		ack_s = o_dma_ack;
		abt_s = o_dma_abort;
		i_dma_req = 1'b0;
		chk1("done", 1'b1, ack_s | abt_s);
		repeat (6) @(posedge i_sys_clk);
		#1;
	endtask : xfer

	task automatic s_hold_read;
		xfer(1'b0, 1'b0, 1'b0, 32'h1234_5678, 16'h0000, 8'h00, 2'h0, 4'h0);
		chk1("own_seen", 1'b1, own_seen);
		chk1("dir_own", 1'b0, dir_own);
		chk16("ext_addr", 16'h1234, cap0);
		chk16("low_addr", 16'h5678, cap1);
		chk1("rd_low", 1'b1, rd_lo);
		chk16("rdata", 16'ha55a, o_dma_rdata);
		chk1("strobe_oe", 1'b0, o_strobe_oe);
		chk1("low_oe", 1'b0, o_addr_data_low_half_oe);
		chk1("bhe_oe", 1'b0, o_upper_byte_or_read_not_write_oe);
		chk1("hold_req", 1'b0, o_hold_request_out);
		chk1("owned_n", 1'b1, o_bus_owned_out_n);
		chk1("dir_idle", 1'b1, o_data_direction_out);
	endtask : s_hold_read

	task automatic s_hold_write;
		xfer(1'b0, 1'b1, 1'b0, 32'h0000_00a0, 16'hc33c, 8'h00, 2'h0, 4'h3);
		chk1("ack", 1'b1, ack_s);
		chk1("wr_len", 1'b1, stb_len > 16'h0003);
		chk1("dir_own", 1'b1, dir_own);
		chk1("wr_low", 1'b1, wr_lo);
		chk1("rd_low", 1'b0, rd_lo);
		chk16("wdata", 16'hc33c, wr_val);
	endtask : s_hold_write

	task automatic s_grant_read;
		xfer(1'b1, 1'b0, 1'b0, 32'h00ab_0010, 16'h0000, 8'h00, 2'h0, 4'h1);
		chk1("breq_low", 1'b1, breq_lo);
		chk1("ds_diff", 1'b0, ds_diff);
		chk1("rnw_low", 1'b0, rnw_lo);
		chk1("dir_own", 1'b0, dir_own);
		chk1("ten_low", 1'b1, ten_lo);
		chk16("rdata", 16'ha55a, o_dma_rdata);
		chk1("breq_n", 1'b1, o_bus_request_out_n);
	endtask : s_grant_read

	task automatic s_grant_retry;
		xfer(1'b1, 1'b1, 1'b0, 32'h0000_0020, 16'h5aa5, 8'h01, 2'h1, 4'h0);
		chk1("ack", 1'b1, ack_s);
		chk1("abort", 1'b0, abt_s);
		chk1("rnw_low", 1'b1, rnw_lo);
		chk1("ds_diff", 1'b1, ds_diff);
		chk1("dir_own", 1'b1, dir_own);
		chk16("wdata", 16'h5aa5, wr_val);
	endtask : s_grant_retry

	task automatic s_grant_abort;
		xfer(1'b1, 1'b0, 1'b0, 32'h0000_0040, 16'h0000, 8'h00, 2'h2, 4'h0);
		chk1("abort", 1'b1, abt_s);
		chk1("ack", 1'b0, ack_s);
	endtask : s_grant_abort

	task automatic s_grant_rerun;
		xfer(1'b1, 1'b0, 1'b0, 32'h0000_0050, 16'h0000, 8'h00, 2'h3, 4'h0);
		chk1("ack", 1'b1, ack_s);
		chk1("abort", 1'b0, abt_s);
		chk16("rdata", 16'ha55a, o_dma_rdata);
	endtask : s_grant_rerun

	task automatic s_grant_byte;
		xfer(1'b1, 1'b1, 1'b1, 32'h0000_0030, 16'h00e7, 8'h00, 2'h0, 4'h0);
		chk1("ack", 1'b1, ack_s);
		chk1("hi_oe", 1'b0, hi_oe);
	endtask : s_grant_byte

	initial begin
		#200000;
		n_fail++;
		results();
	end

	initial begin
		n_fail = 0;
		n_checks = 0;
		i_arst_n = 1'b0;
		i_dma_last = 1'b1;
		{i_req_grant_mode, i_dma_req, i_dma_write, i_dma_byte} = 4'h0;
		i_dma_addr = 32'h0000_0000;
		i_dma_wdata = 16'h0000;
		i_error_retry_count = 8'h00;
		err_mode = 2'h0;
		waits = 4'h0;
		repeat (3) @(posedge i_sys_clk);
		#1 i_arst_n = 1'b1;
		s_hold_read();
		s_hold_write();
		s_grant_read();
		s_grant_retry();
		s_grant_abort();
		s_grant_rerun();
		s_grant_byte();
		results();
	end
endmodule : sys_bus_master_tb
`default_nettype wire
